// File: logic/pss_consts.svh
/*
  Named offsets, field positions, reset values and timing figures of the sequencer.
  Assumes it is included by its bare name from the design file.
*/
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_CMD_UV_ACT      8'h5A
`define PSS_CMD_PG_THR      8'h5E
`define PSS_CMD_ON_DLY      8'h60
`define PSS_CMD_ON_RISE     8'h61
`define PSS_CMD_OFF_DLY     8'h64
`define PSS_CMD_OFF_FALL    8'h65
`define PSS_CMD_STATUS      8'h78

`define PSS_RST_UV_ACT      8'h80
`define PSS_RST_PG_THR      16'h0100
`define PSS_RST_ON_DLY      16'h000A
`define PSS_RST_ON_RISE     16'h0005
`define PSS_RST_OFF_DLY     16'h0005
`define PSS_RST_OFF_FALL    16'h0005

`define PSS_UV_MODE         7:6
`define PSS_UV_RETRY        5:3
`define PSS_UV_RTIME        2:0
`define PSS_MODE_RETRY      2'h2
`define PSS_RETRY_NONE      3'h0
`define PSS_RETRY_FOREVER   3'h7
`define PSS_STAT_OFF        6
`define PSS_STAT_UV         3

`define PSS_LIN_EXP         15:11
`define PSS_LIN_MANT        10:0
`define PSS_LIN_SIGN        10

`define PSS_CLK_NS          32'h00000004
`define PSS_MS_NS           32'h000F4240
`define PSS_RETRY_STEP_MS   9'h023
`define PSS_ON_DLY_MIN_MS   9'h003
`define PSS_ON_DLY_MAX_MS   9'h0FA
`define PSS_OFF_DLY_MIN_MS  9'h004
`define PSS_OFF_DLY_MAX_MS  9'h0FA
`define PSS_RAMP_MIN_MS     9'h000
`define PSS_RAMP_MAX_MS     9'h064

`endif

// File: logic/pss_pkg.sv
/*
  Types of the power sequencer: one-hot state codes and the packed state record.
  Does not include the constants header.
*/
`default_nettype none
package pss_pkg;
  typedef enum logic [7:0] {
    st_off     = 8'h01,
    st_on_dly  = 8'h02,
    st_rise    = 8'h04,
    st_on      = 8'h08,
    st_off_dly = 8'h10,
    st_fall    = 8'h20,
    st_rty     = 8'h40,
    st_hold    = 8'h80
  } pss_state_t;

  typedef struct packed {
    pss_state_t  st;
    logic [17:0] ms_cnt;
    logic [8:0]  tmr;
    logic [2:0]  tries;
    logic [7:0]  uv_act;
    logic [15:0] pg_thr;
    logic [15:0] on_dly;
    logic [15:0] on_rise;
    logic [15:0] off_dly;
    logic [15:0] off_fall;
    logic        uv_q;
    logic        uv_stat;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        pgood;
    logic        alert_n;
    logic        out_on;
    logic        ramp_up;
    logic        ramp_down;
  } pss_regs_t;
endpackage
`default_nettype wire

// File: logic/pss_seq.sv
/*
  On/off sequencer with input under-voltage fault response and power-good flag.
  Assumes a command decoder outside that turns bus transactions into single-cycle
  read and write strobes, and that all inputs are synchronous to clock.
*/
// Contract
// - Response code 10 turns the output off at once, then retries.
// - Any under-voltage fault drives alert low and sets the fault status bit.
// - Retry field sets how many restarts follow an under-voltage shutdown.
// - Retry zero: no restart, output stays off until the fault clears.
// - Retry seven: restart forever until disabled, reset or other fault.
// - Wait between restarts is (retry time plus one) times 35 ms.
// - Power good rises once output voltage reaches the threshold word.
// - Enable waits the turn-on delay, 3 to 250 ms, before rising.
// - Turn-on delay range holds for bus or pin enable in sharing groups.
// - After the delay the output ramps up over rise time, 0 to 100 ms.
// - Disable waits the turn-off delay, 4 to 250 ms, before falling.
// - Zero turn-off delay means immediate off, skipping any soft ramp.
// - After off delay the output ramps down over fall time, 0 to 100 ms.
// - The fault-response setting is read and written as one byte.
`default_nettype none
`include "pss_consts.svh"

module pss_seq
  import pss_pkg::*;
#(
  parameter int CYC_PER_MS = `PSS_MS_NS / `PSS_CLK_NS
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        enable_req,
  input  wire logic        uv_fault,
  input  wire logic        other_fault,
  input  wire logic        clear_faults,
  input  wire logic [15:0] vout_meas,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             power_good_signal,
  output logic             alert_line_n,
  output logic             output_on,
  output logic             ramp_up,
  output logic             ramp_down
);

  // Linear word to whole milliseconds; negative values fall to the lower limit.
  function automatic logic [8:0] lin_ms(input logic [15:0] w, input logic [8:0] lo,
                                        input logic [8:0] hi);
    logic [4:0]  e;
    logic [31:0] v;
    e = w[`PSS_LIN_EXP];
    if (w[`PSS_LIN_SIGN])
      v = 32'h0;
    else if (e[4])
      v = {21'h0, w[`PSS_LIN_MANT]} >> (~e + 5'h1);
    else
      v = {21'h0, w[`PSS_LIN_MANT]} << e[3:0];
    if (v < {23'h0, lo})
      lin_ms = lo;
    else if (v > {23'h0, hi})
      lin_ms = hi;
    else
      lin_ms = v[8:0];
  endfunction

  pss_regs_t r_ff;
  pss_regs_t nxt_r;

  logic       tick;
  logic       done;
  logic       active;
  logic       uv_hit;
  logic [8:0] on_dly_ms;
  logic [8:0] rise_ms;
  logic [8:0] off_dly_ms;
  logic [8:0] fall_ms;
  logic [8:0] rty_ms;
  logic [2:0] retry_set;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.rd_valid = 1'b0;
    tick = (r_ff.ms_cnt == 18'(CYC_PER_MS - 1));
    nxt_r.ms_cnt = tick ? 18'h0 : r_ff.ms_cnt + 18'h1;
    if (tick && r_ff.tmr != 9'h0)
      nxt_r.tmr = r_ff.tmr - 9'h1;
    done = (r_ff.tmr == 9'h0);

    // The same delay range applies whatever source raised enable_req.
    on_dly_ms = lin_ms(r_ff.on_dly, `PSS_ON_DLY_MIN_MS, `PSS_ON_DLY_MAX_MS);
    rise_ms = lin_ms(r_ff.on_rise, `PSS_RAMP_MIN_MS, `PSS_RAMP_MAX_MS);
    off_dly_ms = lin_ms(r_ff.off_dly, `PSS_RAMP_MIN_MS, `PSS_OFF_DLY_MAX_MS);
    if (off_dly_ms != 9'h0)
      off_dly_ms = lin_ms(r_ff.off_dly, `PSS_OFF_DLY_MIN_MS, `PSS_OFF_DLY_MAX_MS);
    fall_ms = lin_ms(r_ff.off_fall, `PSS_RAMP_MIN_MS, `PSS_RAMP_MAX_MS);
    rty_ms = (9'({6'h0, r_ff.uv_act[`PSS_UV_RTIME]}) + 9'h1) * `PSS_RETRY_STEP_MS;
    retry_set = r_ff.uv_act[`PSS_UV_RETRY];

    if (wr_en) begin
      unique case (cmd_code)
        `PSS_CMD_UV_ACT:   nxt_r.uv_act = wr_data[7:0];
        `PSS_CMD_PG_THR:   nxt_r.pg_thr = wr_data;
        `PSS_CMD_ON_DLY:   nxt_r.on_dly = wr_data;
        `PSS_CMD_ON_RISE:  nxt_r.on_rise = wr_data;
        `PSS_CMD_OFF_DLY:  nxt_r.off_dly = wr_data;
        `PSS_CMD_OFF_FALL: nxt_r.off_fall = wr_data;
        default: ;
      endcase
    end
    if (rd_en) begin
      nxt_r.rd_valid = 1'b1;
      nxt_r.rd_data = 16'h0;
      unique case (cmd_code)
        `PSS_CMD_UV_ACT:   nxt_r.rd_data = {8'h0, r_ff.uv_act};
        `PSS_CMD_PG_THR:   nxt_r.rd_data = r_ff.pg_thr;
        `PSS_CMD_ON_DLY:   nxt_r.rd_data = r_ff.on_dly;
        `PSS_CMD_ON_RISE:  nxt_r.rd_data = r_ff.on_rise;
        `PSS_CMD_OFF_DLY:  nxt_r.rd_data = r_ff.off_dly;
        `PSS_CMD_OFF_FALL: nxt_r.rd_data = r_ff.off_fall;
        `PSS_CMD_STATUS: begin
          nxt_r.rd_data[`PSS_STAT_OFF] = (r_ff.st == st_off);
          nxt_r.rd_data[`PSS_STAT_UV] = r_ff.uv_stat;
        end
        default: ;
      endcase
    end

    // A fault present in the clear cycle keeps the bit set.
    nxt_r.uv_q = uv_fault;
    if (clear_faults)
      nxt_r.uv_stat = 1'b0;
    if (uv_fault)
      nxt_r.uv_stat = 1'b1;
    nxt_r.alert_n = ~nxt_r.uv_stat;

    active = (r_ff.st == st_rise) || (r_ff.st == st_on) ||
             (r_ff.st == st_off_dly) || (r_ff.st == st_fall);
    uv_hit = uv_fault && !r_ff.uv_q && (r_ff.uv_act[`PSS_UV_MODE] == `PSS_MODE_RETRY) &&
             (active || r_ff.st == st_on_dly);

    unique case (r_ff.st)
      st_off: begin
        if (enable_req) begin
          nxt_r.st = st_on_dly;
          nxt_r.tmr = on_dly_ms;
          nxt_r.ms_cnt = 18'h0;
          nxt_r.tries = 3'h0;
        end
      end
      st_on_dly: begin
        if (!enable_req)
          nxt_r.st = st_off;
        else if (done) begin
          nxt_r.st = st_rise;
          nxt_r.tmr = rise_ms;
          nxt_r.ms_cnt = 18'h0;
        end
      end
      st_rise, st_on: begin
        if (!enable_req) begin
          if (off_dly_ms == 9'h0)
            nxt_r.st = st_off;
          else begin
            nxt_r.st = st_off_dly;
            nxt_r.tmr = off_dly_ms;
            nxt_r.ms_cnt = 18'h0;
          end
        end else if (r_ff.st == st_rise && done)
          nxt_r.st = st_on;
      end
      st_off_dly: begin
        if (enable_req)
          nxt_r.st = st_on;
        else if (done) begin
          nxt_r.st = st_fall;
          nxt_r.tmr = fall_ms;
          nxt_r.ms_cnt = 18'h0;
        end
      end
      st_fall: begin
        if (done)
          nxt_r.st = st_off;
      end
      st_rty: begin
        if (!enable_req)
          nxt_r.st = st_off;
        else if (done) begin
          nxt_r.st = st_on_dly;
          nxt_r.tmr = on_dly_ms;
          nxt_r.ms_cnt = 18'h0;
        end
      end
      st_hold: begin
        if (!r_ff.uv_stat && !other_fault)
          nxt_r.st = st_off;
      end
    endcase

    // A setting lowered below the count already used must still stop the restarts.
    if (uv_hit) begin
      if (retry_set == `PSS_RETRY_NONE ||
          (retry_set != `PSS_RETRY_FOREVER && r_ff.tries >= retry_set))
        nxt_r.st = st_hold;
      else begin
        nxt_r.st = st_rty;
        nxt_r.tmr = rty_ms;
        nxt_r.ms_cnt = 18'h0;
        if (retry_set != `PSS_RETRY_FOREVER)
          nxt_r.tries = r_ff.tries + 3'h1;
      end
    end
    if (other_fault && r_ff.st != st_off)
      nxt_r.st = st_hold;

    nxt_r.out_on = (nxt_r.st == st_rise) || (nxt_r.st == st_on) ||
                   (nxt_r.st == st_off_dly) || (nxt_r.st == st_fall);
    nxt_r.ramp_up = (nxt_r.st == st_rise);
    nxt_r.ramp_down = (nxt_r.st == st_fall);
    // Power good drops as soon as the fall starts, even while vout is still high.
    nxt_r.pgood = ((nxt_r.st == st_rise) || (nxt_r.st == st_on) ||
                   (nxt_r.st == st_off_dly)) && (vout_meas >= r_ff.pg_thr);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r_ff <= '0;
      r_ff.st <= st_off;
      r_ff.uv_act <= `PSS_RST_UV_ACT;
      r_ff.pg_thr <= `PSS_RST_PG_THR;
      r_ff.on_dly <= `PSS_RST_ON_DLY;
      r_ff.on_rise <= `PSS_RST_ON_RISE;
      r_ff.off_dly <= `PSS_RST_OFF_DLY;
      r_ff.off_fall <= `PSS_RST_OFF_FALL;
      r_ff.alert_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rd_data           = r_ff.rd_data;
  assign rd_valid          = r_ff.rd_valid;
  assign power_good_signal = r_ff.pgood;
  assign alert_line_n      = r_ff.alert_n;
  assign output_on         = r_ff.out_on;
  assign ramp_up           = r_ff.ramp_up;
  assign ramp_down         = r_ff.ramp_down;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_uv_hit;
    uv_hit && !other_fault;
  endsequence

  sequence s_enter_rty;
    r_ff.st != st_rty ##1 r_ff.st == st_rty;
  endsequence

  property p_uv_off;
    s_uv_hit |=> !output_on && (r_ff.st == st_rty || r_ff.st == st_hold);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("output not cut on uv fault");

  property p_alert;
    uv_fault |=> !alert_line_n && r_ff.uv_stat;
  endproperty
  a_alert: assert property (p_alert) else $error("alert or fault bit missing");

  property p_tries;
    s_uv_hit ##0 retry_set != `PSS_RETRY_FOREVER |=> r_ff.tries <= $past(retry_set);
  endproperty
  a_tries: assert property (p_tries) else $error("too many restarts");

  property p_no_retry;
    s_uv_hit ##0 retry_set == `PSS_RETRY_NONE |=> r_ff.st == st_hold;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with retry zero");

  property p_hold_off;
    r_ff.st == st_hold && r_ff.uv_stat |=> !output_on;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output on during hold");

  property p_forever;
    s_uv_hit ##0 retry_set == `PSS_RETRY_FOREVER |=> r_ff.st == st_rty;
  endproperty
  a_forever: assert property (p_forever) else $error("continuous retry stopped");

  property p_rty_time;
    s_enter_rty |-> r_ff.tmr == $past(rty_ms);
  endproperty
  a_rty_time: assert property (p_rty_time) else $error("wrong retry wait");

  property p_pgood;
    power_good_signal |-> $past(vout_meas) >= $past(r_ff.pg_thr);
  endproperty
  a_pgood: assert property (p_pgood) else $error("power good below threshold");

  property p_on_dly;
    r_ff.st == st_off && enable_req |=> r_ff.st == st_on_dly &&
      r_ff.tmr >= `PSS_ON_DLY_MIN_MS && r_ff.tmr <= `PSS_ON_DLY_MAX_MS;
  endproperty
  a_on_dly: assert property (p_on_dly) else $error("turn-on delay out of range");

  property p_rise;
    r_ff.st == st_rise |-> ramp_up && output_on && r_ff.tmr <= `PSS_RAMP_MAX_MS;
  endproperty
  a_rise: assert property (p_rise) else $error("rise ramp not shown");

  property p_imm_off;
    r_ff.st == st_on && !enable_req && off_dly_ms == 9'h0 && !uv_hit
      |=> !output_on && !ramp_down;
  endproperty
  a_imm_off: assert property (p_imm_off) else $error("no immediate off");

  property p_uv_byte;
    wr_en && cmd_code == `PSS_CMD_UV_ACT ##1 rd_en && cmd_code == `PSS_CMD_UV_ACT
      |=> rd_valid && rd_data == {8'h0, $past(wr_data[7:0], 2)};
  endproperty
  a_uv_byte: assert property (p_uv_byte) else $error("fault action byte lost");

endmodule
`default_nettype wire

// File: verif/pss_vout_model.sv
/*
  Behavioural model of the regulator output voltage seen by the sequencer.
  Assumes the sequencer's enable and ramp flags, sampled on the rising clock.
*/
`default_nettype none
module pss_vout_model #(
  parameter logic [15:0] FULL = 16'h0300,
  parameter logic [15:0] STEP = 16'h0010
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        output_on,
  input  wire logic        ramp_up,
  input  wire logic        ramp_down,
  output logic      [15:0] vout_meas
);
  timeunit 1ns;
  timeprecision 100ps;
  // Ramps move in steps, so the threshold is crossed mid-rise rather than at once.
  always @(posedge clock) begin
    if (sys_rst || !output_on) begin
      vout_meas <= 16'h0000;
    end else if (ramp_up) begin
      vout_meas <= (vout_meas > FULL - STEP) ? FULL : vout_meas + STEP;
    end else if (ramp_down) begin
      vout_meas <= (vout_meas < STEP) ? 16'h0000 : vout_meas - STEP;
    end else begin
      vout_meas <= FULL;
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
/*
  Self-checking bench of the sequencer: register access, on/off timing, fault response.
  Assumes four clocks per millisecond so that every delay stays short.
*/
`default_nettype none
module testbench import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int C = 4;
  localparam int T = 5;
  logic        clock, sys_rst, enable_req, uv_fault, other_fault, clear_faults, wr_en, rd_en;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data, rd_data, vout_meas, v;
  logic        rd_valid, power_good_signal, alert_line_n, output_on, ramp_up, ramp_down;
  int          failures, compares, n;
  logic [7:0]  cmds [7] = '{8'h5A, 8'h5E, 8'h60, 8'h61, 8'h64, 8'h65, 8'h33};
  logic [15:0] rv   [7] = '{16'h0080, 16'h0100, 16'h000A, 16'h0005, 16'h0005, 16'h0005, 16'h0000};
  logic [15:0] wv   [7] = '{16'h00A5, 16'hC3A5, 16'hC3A5, 16'hC3A5, 16'hC3A5, 16'hC3A5, 16'h0000};

  pss_seq #(.CYC_PER_MS(C)) pss_seq_i (.clock(clock), .sys_rst(sys_rst),
    .enable_req(enable_req), .uv_fault(uv_fault), .other_fault(other_fault),
    .clear_faults(clear_faults), .vout_meas(vout_meas), .cmd_code(cmd_code), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .power_good_signal(power_good_signal), .alert_line_n(alert_line_n),
    .output_on(output_on), .ramp_up(ramp_up), .ramp_down(ramp_down));
  pss_vout_model pss_vout_model_i (.clock(clock), .sys_rst(sys_rst), .output_on(output_on),
    .ramp_up(ramp_up), .ramp_down(ramp_down), .vout_meas(vout_meas));

  always #2 clock = ~clock;

  task automatic close_out;
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock);
    cmd_code <= c;
    wr_data  <= d;
    wr_en    <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clock);
    cmd_code <= c;
    rd_en    <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk({15'h0000, rd_valid}, 16'h0001);
    d = rd_data;
  endtask

  // Write and read back in adjacent cycles, the tightest spacing the port allows.
  task automatic wrd(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    cmd_code <= c;
    wr_data  <= d;
    wr_en    <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk({15'h0000, rd_valid}, 16'h0001);
    q = rd_data;
  endtask

  // The wait gives up after lim edges and then reports lim, which refusals rely on.
  task automatic wt(input int s, input logic b, input int lim, output int k);
    k = 0;
    while (k < lim) begin
      @(posedge clock);
      #1;
      k++;
      if ((s == 0 ? ramp_up : s == 1 ? output_on : ramp_down) === b) break;
    end
  endtask

  task automatic en(input logic b);
    @(posedge clock);
    enable_req <= b;
  endtask

  task automatic hit;
    @(posedge clock);
    uv_fault <= 1'b1;
    @(posedge clock);
    uv_fault <= 1'b0;
    #1;
  endtask

  task automatic clr;
    @(posedge clock);
    enable_req   <= 1'b0;
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  initial begin
    #80000;
    failures++;
    close_out();
  end

  initial begin
    {clock, sys_rst, enable_req, uv_fault, other_fault, clear_faults, wr_en, rd_en} = 8'h40;
    cmd_code = 8'h00;
    wr_data  = 16'h0000;
    failures = 0;
    compares = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(cmds[i], v);
      chk(v, rv[i]);
      wrd(cmds[i], 16'hC3A5, v);
      chk(v, wv[i]);
    end
    rd(8'h78, v);
    chk(v, 16'h0040);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    wr(8'h60, 16'h001E);
    wr(8'h61, 16'h00C8);
    en(1'b1);
    wt(0, 1'b1, 2000, n);
    rng(n, 30 * C, 30 * C + T);
    wt(0, 1'b0, 2000, n);
    rng(n, 100 * C, 100 * C + T);
    chk({15'h0000, power_good_signal}, 16'h0001);
    en(1'b0);
    wt(2, 1'b1, 2000, n);
    rng(n, 5 * C, 5 * C + T);
    wt(1, 1'b0, 2000, n);
    rng(n, 5 * C, 5 * C + T);
    wr(8'h64, 16'h0000);
    wr(8'h60, 16'h0001);
    wr(8'h61, 16'h0000);
    wr(8'h5E, 16'hFFFF);
    en(1'b1);
    wt(1, 1'b1, 2000, n);
    rng(n, 3 * C, 3 * C + T);
    repeat (8) @(posedge clock);
    chk({15'h0000, power_good_signal}, 16'h0000);
    en(1'b0);
    wt(1, 1'b0, 50, n);
    rng(n, 1, 2);
    chk({15'h0000, ramp_down}, 16'h0000);
    wr(8'h5A, 16'h0089);
    en(1'b1);
    wt(1, 1'b1, 200, n);
    hit();
    chk({15'h0000, output_on}, 16'h0000);
    chk({15'h0000, alert_line_n}, 16'h0000);
    wt(1, 1'b1, 1000, n);
    rng(n, 73 * C - 2, 73 * C + T);
    hit();
    wt(1, 1'b1, 400, n);
    rng(n, 400, 400);
    rd(8'h78, v);
    chk(v, 16'h0008);
    clr();
    chk({15'h0000, alert_line_n}, 16'h0001);
    wr(8'h5A, 16'h0080);
    en(1'b1);
    wt(1, 1'b1, 200, n);
    hit();
    wt(1, 1'b1, 400, n);
    rng(n, 400, 400);
    clr();
    wr(8'h5A, 16'h00B8);
    en(1'b1);
    wt(1, 1'b1, 200, n);
    repeat (3) begin
      hit();
      wt(1, 1'b1, 400, n);
      rng(n, 38 * C - 2, 38 * C + T);
    end
    @(posedge clock);
    other_fault <= 1'b1;
    @(posedge clock);
    other_fault <= 1'b0;
    wt(1, 1'b1, 400, n);
    rng(n, 400, 400);
    clr();
    wr(8'h5A, 16'h0008);
    en(1'b1);
    wt(1, 1'b1, 200, n);
    hit();
    chk({15'h0000, output_on}, 16'h0001);
    chk({15'h0000, alert_line_n}, 16'h0000);
    // A fault arriving in the clear cycle must keep the flag and the alert.
    @(posedge clock);
    uv_fault     <= 1'b1;
    clear_faults <= 1'b1;
    @(posedge clock);
    uv_fault     <= 1'b0;
    clear_faults <= 1'b0;
    #1;
    chk({15'h0000, alert_line_n}, 16'h0000);
    clr();
    chk({15'h0000, alert_line_n}, 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
